/* File: pkg/eeb_pkg.sv */
package eeb_pkg;
  // Bus geometry
  localparam int ADDR_W = 12;
  localparam int PAGE_W = 5;
  localparam int PAGE_BYTES = 32;
  localparam int CNT_W = 4;
  localparam logic [3:0] CNT_ACK = 4'h8;
  localparam logic [3:0] CTRL_TYPE = 4'hA;
  // Input synchroniser lanes
  localparam int PIN_W = 6;
  localparam logic [5:0] PIN_IDLE = 6'h03;
  localparam int PIN_SCL = 0;
  localparam int PIN_SDA = 1;
  localparam int PIN_WP = 2;
  localparam int PIN_CS = 3;
  // Timing at the reference clock
  localparam int CLK_PS = 8000;
  localparam int HOLD_NS = 300;
  localparam int HOLD_CYC = (HOLD_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int DLY_W = 6;
  localparam longint WC_MS = 5;
  localparam int WC_CYC_DEF = int'(WC_MS * 64'd1000000000 / CLK_PS);
  localparam int WC_W = 20;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CTRL = 3'b001,
    ST_AHI = 3'b010,
    ST_ALO = 3'b011,
    ST_WDAT = 3'b100,
    ST_RDAT = 3'b101
  } eeb_state_t;
endpackage

/* File: rtl/eeb_sync.sv */
`timescale 1ns/1ps
module eeb_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '1
) (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire logic [W-1:0] i_pin,
  output logic [W-1:0] o_pin
);
  logic [W-1:0] f1_q, f2_q, f3_q, out_q;
  logic [W-1:0] out_d;

  // Each lane moves only once stages two and three agree
  always_comb begin
    out_d = out_q;
    for (int k = 0; k < W; k++) begin
      if (f2_q[k] == f3_q[k]) begin
        out_d[k] = f3_q[k];
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      f1_q <= RST;
      f2_q <= RST;
      f3_q <= RST;
      out_q <= RST;
    end else if (i_clk_en) begin
      f1_q <= i_pin;
      f2_q <= f1_q;
      f3_q <= f2_q;
      out_q <= out_d;
    end
  end

  assign o_pin = out_q;
endmodule

/* File: rtl/eeb_slave.sv */
`timescale 1ns/1ps
module eeb_slave
  import eeb_pkg::*;
#(
  parameter int WC_CYC = eeb_pkg::WC_CYC_DEF
) (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe_n,
  input wire logic i_chip_select_bit_low,
  input wire logic i_chip_select_bit_mid,
  input wire logic i_chip_select_bit_high,
  input wire logic i_write_protect,
  output logic [eeb_pkg::ADDR_W-1:0] o_mem_addr,
  output logic [7:0] o_mem_wdata,
  output logic o_mem_we,
  input wire logic [7:0] i_mem_rdata,
  output logic o_busy
);
  import eeb_pkg::*;

  logic [PIN_W-1:0] pins;
  logic scl_s, sda_s, wp_s, scl_p_q, sda_p_q;
  logic [2:0] cs_s;
  logic start, stop, scl_rise, scl_fall, ack_in, ack_out, want;

  eeb_sync #(.W(PIN_W), .RST(PIN_IDLE)) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_clk_en(i_clk_en),
    .i_pin({i_chip_select_bit_high, i_chip_select_bit_mid, i_chip_select_bit_low,
            i_write_protect, i_sda, i_scl}),
    .o_pin(pins)
  );

  assign scl_s = pins[PIN_SCL];
  assign sda_s = pins[PIN_SDA];
  assign wp_s = pins[PIN_WP];
  assign cs_s = pins[PIN_CS +: 3];

  eeb_state_t st_q, st_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic ack_ph_q, ack_ph_d, ack_go_q, ack_go_d, mack_q, mack_d;
  logic [7:0] shr_q, shr_d, txr_q, txr_d;
  logic [ADDR_W-1:0] ptr_q, ptr_d, maddr_q, maddr_d;
  logic [ADDR_W-PAGE_W-1:0] page_q, page_d;
  logic [7:0] pbuf_q [PAGE_BYTES];
  logic [7:0] pbuf_d [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] vld_q, vld_d;
  logic wr_pend_q, wr_pend_d, busy_q, busy_d, we_q, we_d, oe_n_q, oe_n_d, sda_q;
  logic [WC_W-1:0] wc_q, wc_d;
  logic [PAGE_W:0] ci_q, ci_d;
  logic [DLY_W-1:0] dly_q, dly_d;
  logic [7:0] mwd_q, mwd_d;

  assign start = scl_s && scl_p_q && sda_p_q && !sda_s;
  assign stop = scl_s && scl_p_q && !sda_p_q && sda_s;
  assign scl_rise = scl_s && !scl_p_q;
  assign scl_fall = !scl_s && scl_p_q;
  assign ack_in = scl_fall && cnt_q == CNT_ACK && !ack_ph_q;
  assign ack_out = scl_fall && ack_ph_q;
  // Drive low for an acknowledge or a zero data bit, otherwise release
  assign want = (ack_ph_q && ack_go_q) || (st_q == ST_RDAT && !ack_ph_q && !txr_q[7]);

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    ack_ph_d = ack_ph_q;
    ack_go_d = ack_go_q;
    mack_d = mack_q;
    shr_d = shr_q;
    txr_d = txr_q;
    ptr_d = ptr_q;
    page_d = page_q;
    pbuf_d = pbuf_q;
    vld_d = vld_q;
    wr_pend_d = wr_pend_q;
    busy_d = busy_q;
    wc_d = wc_q;
    ci_d = ci_q;
    dly_d = dly_q;
    oe_n_d = oe_n_q;
    maddr_d = ptr_q;
    mwd_d = mwd_q;
    we_d = 1'b0;
    // Output moves after the hold delay while SCL is low; start and stop release it at once
    if (dly_q != '0) begin
      if (scl_s) begin
        dly_d = dly_q;
      end else begin
        dly_d = dly_q - DLY_W'(1);
        if (dly_q == DLY_W'(1)) begin
          oe_n_d = !want;
        end
      end
    end
    if (start) begin
      st_d = ST_CTRL;
      cnt_d = '0;
      ack_ph_d = 1'b0;
      ack_go_d = 1'b0;
      wr_pend_d = 1'b0;
      oe_n_d = 1'b1;
      dly_d = '0;
    end else if (stop) begin
      st_d = ST_IDLE;
      cnt_d = '0;
      ack_ph_d = 1'b0;
      ack_go_d = 1'b0;
      oe_n_d = 1'b1;
      dly_d = '0;
      wr_pend_d = 1'b0;
      // Protect pin is sampled here; a later toggle has no effect
      if (wr_pend_q && !wp_s) begin
        busy_d = 1'b1;
        wc_d = '0;
        ci_d = '0;
      end
    end else if (st_q != ST_IDLE) begin
      if (scl_rise) begin
        if (ack_ph_q) begin
          mack_d = !sda_s;
        end else if (cnt_q != CNT_ACK) begin
          shr_d = {shr_q[6:0], sda_s};
          txr_d = {txr_q[6:0], 1'b1};
          cnt_d = cnt_q + CNT_W'(1);
        end
      end
      if (scl_fall) begin
        dly_d = DLY_W'(HOLD_CYC);
      end
      if (ack_in) begin
        ack_ph_d = 1'b1;
        ack_go_d = 1'b0;
        unique case (st_q)
          ST_IDLE: begin
          end
          ST_CTRL: begin
            if (shr_q[7:4] == CTRL_TYPE && shr_q[3:1] == cs_s && !busy_q) begin
              ack_go_d = 1'b1;
              mack_d = 1'b1;
              st_d = shr_q[0] ? ST_RDAT : ST_AHI;
            end else begin
              st_d = ST_IDLE;
            end
          end
          ST_AHI: begin
            ptr_d[ADDR_W-1:8] = shr_q[ADDR_W-9:0];
            ack_go_d = 1'b1;
            st_d = ST_ALO;
          end
          ST_ALO: begin
            ptr_d[7:0] = shr_q;
            page_d = {ptr_q[ADDR_W-1:8], shr_q[7:PAGE_W]};
            vld_d = '0;
            ack_go_d = 1'b1;
            st_d = ST_WDAT;
          end
          ST_WDAT: begin
            // Index wrap overwrites oldest bytes in the page buffer
            pbuf_d[ptr_q[PAGE_W-1:0]] = shr_q;
            vld_d[ptr_q[PAGE_W-1:0]] = 1'b1;
            ptr_d[PAGE_W-1:0] = ptr_q[PAGE_W-1:0] + PAGE_W'(1);
            ack_go_d = 1'b1;
            wr_pend_d = 1'b1;
          end
          ST_RDAT: begin
            ptr_d = ptr_q + ADDR_W'(1);
          end
        endcase
      end else if (ack_out) begin
        ack_ph_d = 1'b0;
        ack_go_d = 1'b0;
        cnt_d = '0;
        if (st_q == ST_RDAT) begin
          if (mack_q) begin
            txr_d = i_mem_rdata;
          end else begin
            st_d = ST_IDLE;
          end
        end
      end
    end
    // Page commit, one byte a cycle, then wait out the cycle time
    if (busy_q) begin
      wc_d = wc_q + WC_W'(1);
      if (!ci_q[PAGE_W]) begin
        ci_d = ci_q + (PAGE_W + 1)'(1);
        maddr_d = {page_q, ci_q[PAGE_W-1:0]};
        mwd_d = pbuf_q[ci_q[PAGE_W-1:0]];
        we_d = vld_q[ci_q[PAGE_W-1:0]];
      end
      if (wc_q == WC_W'(WC_CYC - 1)) begin
        busy_d = 1'b0;
        vld_d = '0;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      st_q <= ST_IDLE;
      cnt_q <= '0;
      ack_ph_q <= 1'b0;
      ack_go_q <= 1'b0;
      mack_q <= 1'b0;
      shr_q <= '0;
      txr_q <= '1;
      ptr_q <= '0;
      page_q <= '0;
      pbuf_q <= '{default: '0};
      vld_q <= '0;
      wr_pend_q <= 1'b0;
      busy_q <= 1'b0;
      wc_q <= '0;
      ci_q <= '0;
      dly_q <= '0;
      oe_n_q <= 1'b1;
      maddr_q <= '0;
      mwd_q <= '0;
      we_q <= 1'b0;
      sda_q <= 1'b0;
    end else if (i_clk_en) begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
      st_q <= st_d;
      cnt_q <= cnt_d;
      ack_ph_q <= ack_ph_d;
      ack_go_q <= ack_go_d;
      mack_q <= mack_d;
      shr_q <= shr_d;
      txr_q <= txr_d;
      ptr_q <= ptr_d;
      page_q <= page_d;
      pbuf_q <= pbuf_d;
      vld_q <= vld_d;
      wr_pend_q <= wr_pend_d;
      busy_q <= busy_d;
      wc_q <= wc_d;
      ci_q <= ci_d;
      dly_q <= dly_d;
      oe_n_q <= oe_n_d;
      maddr_q <= maddr_d;
      mwd_q <= mwd_d;
      we_q <= we_d;
      sda_q <= 1'b0;
    end
  end

  assign o_sda = sda_q;
  assign o_sda_oe_n = oe_n_q;
  assign o_mem_addr = maddr_q;
  assign o_mem_wdata = mwd_q;
  assign o_mem_we = we_q;
  assign o_busy = busy_q;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst || !i_clk_en);

  a_start_ctrl: assert property (start |=> st_q == ST_CTRL && cnt_q == '0)
    else $error("start did not restart the control byte");
  a_stop_idle: assert property (stop |=> st_q == ST_IDLE && o_sda_oe_n)
    else $error("stop did not idle and release");
  a_busy_noack: assert property (ack_in && st_q == ST_CTRL && busy_q |=> !ack_go_q)
    else $error("acknowledge given while busy");
  a_type_check: assert property (ack_in && st_q == ST_CTRL && shr_q[7:4] != CTRL_TYPE
    |=> !ack_go_q && st_q == ST_IDLE)
    else $error("wrong type code acknowledged");
  a_cs_check: assert property (ack_in && st_q == ST_CTRL && shr_q[3:1] != cs_s
    |=> !ack_go_q)
    else $error("wrong chip select acknowledged");
  a_rw_select: assert property (ack_in && st_q == ST_CTRL && !busy_q
    && shr_q[7:1] == {CTRL_TYPE, cs_s}
    |=> st_q == ($past(shr_q[0]) ? ST_RDAT : ST_AHI) && ack_go_q)
    else $error("control byte mode wrong");
  a_hold_delay: assert property (scl_fall |=> $stable(o_sda_oe_n) [*8])
    else $error("sda moved too soon after scl fall");
  a_ack_low: assert property (ack_ph_q && ack_go_q && scl_s && !start |-> !o_sda_oe_n)
    else $error("acknowledge not low during clock high");
  a_nack_release: assert property (ack_out && st_q == ST_RDAT && !mack_q
    |=> st_q == ST_IDLE ##1 o_sda_oe_n)
    else $error("sda not released after nack");
  a_page_wrap: assert property (ack_in && st_q == ST_WDAT
    |=> ptr_q[ADDR_W-1:PAGE_W] == $past(ptr_q[ADDR_W-1:PAGE_W]))
    else $error("page write left its page");
  a_wc_bound: assert property (busy_q |-> wc_q < WC_W'(WC_CYC))
    else $error("write cycle overran");
  a_wp_skip: assert property (stop && wr_pend_q && wp_s && !busy_q |=> !busy_q)
    else $error("protected write started a cycle");
endmodule

/* File: verification/eeb_master.sv */
`timescale 1ns/1ps
module eeb_master #(
  parameter int H = 82
) (
  input wire logic i_ref_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_oe_n
);
  initial begin
    o_scl = 1'b1;
    o_sda_oe_n = 1'b1;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask

  // Released data floats to the pull-up, so no stale level survives
  task automatic step(input logic scl, input logic sda_n, input int n);
    o_scl <= scl;
    o_sda_oe_n <= sda_n;
    hold(n);
  endtask

  task automatic start();
    step(1'b0, o_sda_oe_n, H);
    step(1'b0, 1'b1, H);
    step(1'b1, 1'b1, 2 * H);
    step(1'b1, 1'b0, 2 * H);
  endtask

  task automatic stop();
    step(1'b0, o_sda_oe_n, H);
    step(1'b0, 1'b0, H);
    step(1'b1, 1'b0, 2 * H);
    step(1'b1, 1'b1, 2 * H);
  endtask

  // Data moves mid-low, a full half level clear of both clock edges
  task automatic xfer(input logic b, output logic r);
    step(1'b0, o_sda_oe_n, H);
    step(1'b0, b, H);
    step(1'b1, b, H);
    r = i_sda;
    hold(H);
  endtask

  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer(d[i], r);
    end
    xfer(1'b1, r);
    ack = ~r;
  endtask

  task automatic rd_byte(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer(1'b1, r);
      d[i] = r;
    end
    xfer(~mack, r);
  endtask
endmodule

/* File: verification/eeb_slave_tb.sv */
`timescale 1ns/1ps
module eeb_slave_tb;
  import eeb_pkg::*;
  localparam int WC = 4000;
  logic i_ref_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [2:0] cs_pins = 3'h0;
  logic wp = 1'b0;
  logic [7:0] rdata = 8'h00;
  logic scl, m_oe_n, s_sda, s_oe_n, we, busy;
  logic [ADDR_W-1:0] maddr;
  logic [7:0] wdata;
  logic [7:0] mem [0:4095];
  logic [7:0] expm [0:4095];
  logic [15:0] seed = 16'h22f0;
  int fails = 0;
  int checked = 0;
  int cyc = 0;
  wire sda = (s_oe_n | s_sda) & m_oe_n;

  initial forever #4 i_ref_clk = ~i_ref_clk;

  eeb_slave #(.WC_CYC(WC)) uut (
    .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_clk_en(1'b1),
    .i_scl(scl), .i_sda(sda), .o_sda(s_sda), .o_sda_oe_n(s_oe_n),
    .i_chip_select_bit_low(cs_pins[0]), .i_chip_select_bit_mid(cs_pins[1]),
    .i_chip_select_bit_high(cs_pins[2]), .i_write_protect(wp),
    .o_mem_addr(maddr), .o_mem_wdata(wdata), .o_mem_we(we),
    .i_mem_rdata(rdata), .o_busy(busy)
  );

  eeb_master m (.i_ref_clk(i_ref_clk), .i_sda(sda), .o_scl(scl), .o_sda_oe_n(m_oe_n));

  // Array stand-in: read data one clock behind the address
  always @(posedge i_ref_clk) begin
    cyc <= cyc + 1;
    if (we) begin
      mem[maddr] <= wdata;
    end
    rdata <= mem[maddr];
  end

  function automatic logic [7:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed[7:0];
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("Counts: %0d checks, %0d mismatches", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic send(input logic [7:0] b, input logic ack);
    logic a;
    m.wr_byte(b, a);
    chk(a, ack, "acknowledge");
  endtask

  task automatic wait_idle();
    for (int n = 0; n < WC + 500 && busy !== 1'b0; n++) begin
      @(posedge i_ref_clk);
    end
    if (busy !== 1'b0) begin
      fails++;
      $display("CHECK FAILED at %0t: write cycle never ended", $time);
      complete_run();
    end
  endtask

  initial begin
    logic [7:0] d;
    logic [7:0] hi;
    logic [2:0] cs;
    logic a;
    int t0;
    for (int i = 0; i < 4096; i++) begin
      mem[i] = rnd();
      expm[i] = mem[i];
    end
    d = rnd();
    cs = d[2:0];
    repeat (2) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    cs_pins <= cs;
    repeat (8) @(posedge i_ref_clk);
    chk(s_oe_n, 1'b1, "idle release");
    chk(s_sda, 1'b0, "open drain level");
    chk({we, busy}, 2'b00, "idle strobes");
    m.start();
    send({4'hB, cs, 1'b0}, 1'b0);
    m.stop();
    m.start();
    send({CTRL_TYPE, cs ^ 3'h5, 1'b0}, 1'b0);
    m.stop();
    // Page write starting two slots before the page end
    m.start();
    send({CTRL_TYPE, cs, 1'b0}, 1'b1);
    hi = rnd();
    send({hi[7:4], 4'h7}, 1'b1);
    send(8'hde, 1'b1);
    for (int k = 0; k < 4; k++) begin
      d = rnd();
      expm[{4'h7, 3'h6, 5'(30 + k)}] = d;
      send(d, 1'b1);
    end
    m.stop();
    t0 = cyc;
    chk(busy, 1'b1, "write cycle start");
    m.start();
    send({CTRL_TYPE, cs, 1'b0}, 1'b0);
    m.stop();
    wait_idle();
    chk(16'(cyc - t0 <= WC), 16'h0001, "write cycle length");
    m.start();
    send({CTRL_TYPE, cs, 1'b0}, 1'b1);
    m.stop();
    for (int k = 0; k < 32; k++) begin
      chk(mem[12'h7c0 + k], expm[12'h7c0 + k], "page contents");
    end
    // Protected write is acknowledged but never committed
    wp <= 1'b1;
    m.start();
    send({CTRL_TYPE, cs, 1'b0}, 1'b1);
    send(8'h07, 1'b1);
    send(8'hc0, 1'b1);
    send(rnd(), 1'b1);
    m.stop();
    repeat (60) @(posedge i_ref_clk);
    chk(busy, 1'b0, "protected busy");
    chk(mem[12'h7c0], expm[12'h7c0], "protected data");
    wp <= 1'b0;
    // Pointer at the top, a byte cut short, then a repeated start read
    m.start();
    send({CTRL_TYPE, cs, 1'b0}, 1'b1);
    send(8'hff, 1'b1);
    send(8'hff, 1'b1);
    for (int k = 0; k < 3; k++) begin
      m.xfer(1'b0, a);
    end
    m.start();
    send({CTRL_TYPE, cs, 1'b1}, 1'b1);
    m.rd_byte(1'b1, d);
    chk(d, expm[12'hfff], "read top");
    m.rd_byte(1'b0, d);
    chk(d, expm[12'h000], "read rollover");
    chk(s_oe_n, 1'b1, "release after last");
    m.stop();
    repeat (60) @(posedge i_ref_clk);
    chk(busy, 1'b0, "cut byte not stored");
    complete_run();
  end
endmodule
